// ### core/ncp_pkg.sv
// Constants and types of the flash command port host controller
package ncp_pkg;
  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_NS = 20;
  localparam int T_WP_NS = 12;
  localparam int T_WH_NS = 10;
  localparam int T_REA_NS = 20;
  localparam int T_WHR_NS = 60;
  localparam int T_WB_NS = 100;
  // Least times round up; one extra cycle on the read pulse for sampling
  localparam logic [3:0] WP_CYC = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] WH_CYC = 4'((T_WH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] RD_LOW_CYC = 4'((T_REA_NS + CLK_NS - 1) / CLK_NS + 1);
  localparam logic [3:0] WHR_CYC = 4'((T_WHR_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] WB_CYC = 4'((T_WB_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] DGAP_CYC = 4'h1;
  // ------------------------------------------------------------
  // Register map (byte offsets)
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_COL = 8'h08;
  localparam logic [7:0] OFF_ROW = 8'h0c;
  localparam logic [7:0] OFF_AGO = 8'h10;
  localparam logic [7:0] OFF_DATA = 8'h14;
  localparam logic [7:0] OFF_STAT = 8'h18;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam int CTRL_CE_B = 0;
  localparam int CTRL_WPN_B = 1;
  localparam int DATA_RD_B = 8;
  localparam int STAT_ERR_B = 2;
  localparam int ST_FAIL_B = 0;
  localparam int ST_D0_B = 1;
  localparam int ST_D1_B = 2;
  localparam int ST_PROT_B = 7;
  localparam int COL_W = 13;
  localparam int ROW_W = 18;
  localparam int WL_W = 6;
  localparam logic [12:0] COL_LAST = 13'h107f;
  // Address go modes: full five cycles, column only, row only
  localparam logic [1:0] AGO_COL = 2'h1;
  localparam logic [1:0] AGO_ROW = 2'h2;
  // ------------------------------------------------------------
  // Opcodes
  // ------------------------------------------------------------
  localparam logic [7:0] OP_READ = 8'h00;
  localparam logic [7:0] OP_READ_GO = 8'h30;
  localparam logic [7:0] OP_COLRD = 8'h05;
  localparam logic [7:0] OP_COLRD_GO = 8'he0;
  localparam logic [7:0] OP_PROG = 8'h80;
  localparam logic [7:0] OP_COLWR = 8'h85;
  localparam logic [7:0] OP_PROG_GO = 8'h10;
  localparam logic [7:0] OP_MPROG_1 = 8'h11;
  localparam logic [7:0] OP_MPROG_2 = 8'h81;
  localparam logic [7:0] OP_CPBK = 8'h35;
  localparam logic [7:0] OP_ERASE = 8'h60;
  localparam logic [7:0] OP_ERASE_GO = 8'hd0;
  localparam logic [7:0] OP_ID = 8'h90;
  localparam logic [7:0] OP_STAT = 8'h70;
  localparam logic [7:0] OP_MSTAT = 8'h71;
  localparam logic [7:0] OP_ECC = 8'h7a;
  localparam logic [7:0] OP_RESET = 8'hff;
  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_WAIT = 5'b00010,
    ST_LOW = 5'b00100,
    ST_HIGH = 5'b01000,
    ST_GAP = 5'b10000
  } ncp_state_t;
  typedef enum logic [1:0] {K_CMD = 2'h0, K_ADDR = 2'h1, K_DWR = 2'h2, K_DRD = 2'h3} ncp_kind_t;
  typedef struct packed {
    ncp_kind_t kind;
    logic [7:0] val;
    logic [2:0] idx;
    logic [2:0] last;
  } ncp_op_t;
  typedef struct packed {
    logic cle;
    logic ale;
    logic we_n;
    logic ostb_n;
    logic oe_n;
    logic [7:0] dout;
  } ncp_pins_t;
endpackage

// ### core/ncp_host.sv
// Host controller driving a multiplexed flash command port from AHB-Lite
`timescale 1ns/1ps
module ncp_host (
  // Clock, reset, enable
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  input wire logic CLK_EN_IN,
  // AHB-Lite slave
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  // Flash port
  output logic CMD_LATCH_OUT,
  output logic ADDR_LATCH_OUT,
  output logic CHIP_SEL_N_OUT,
  output logic WRITE_STROBE_N_OUT,
  output logic OUTPUT_STROBE_N_OUT,
  output logic WRITE_PROT_N_OUT,
  input wire logic [7:0] SHARED_BUS_IN,
  output logic [7:0] SHARED_BUS_OUT,
  output logic SHARED_BUS_OE_N_OUT,
  input wire logic READY_BUSY_N_IN
);
  import ncp_pkg::*;

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  ncp_state_t state_reg;
  ncp_op_t op_reg;
  ncp_pins_t pins_reg;
  logic [3:0] cnt_reg;
  logic [1:0] ctrl_reg;
  logic [COL_W-1:0] col_reg;
  logic [ROW_W-1:0] row_reg;
  logic [7:0] rd_byte_reg;
  logic [15:0] rd_count_reg;
  logic err_reg;
  logic stat_mode_reg;
  logic ce_n_reg;
  logic dp_valid_reg;
  logic dp_write_reg;
  logic [7:0] dp_addr_reg;
  logic [31:0] hrdata_reg;
  logic is_op;
  logic stall;
  logic wr_ok;
  logic refuse;
  logic start;
  logic need_ready;
  ncp_op_t op_next;
  logic [7:0] cur_byte;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] addr_byte(input logic [2:0] i, input logic [12:0] c,
                                           input logic [17:0] r);
    case (i)
      3'h0: addr_byte = c[7:0];
      3'h1: addr_byte = {3'h0, c[12:8]};
      3'h2: addr_byte = r[7:0];
      3'h3: addr_byte = r[15:8];
      default: addr_byte = {6'h0, r[17:16]};
    endcase
  endfunction

  function automatic logic [31:0] read_mux(input logic [7:0] a);
    case (a)
      OFF_CTRL: read_mux = {30'h0, ctrl_reg};
      OFF_COL: read_mux = {19'h0, col_reg};
      OFF_ROW: read_mux = {14'h0, row_reg};
      OFF_DATA: read_mux = {24'h0, rd_byte_reg};
      // Read count, last byte read back and its decoded status bits, error flag, ready pin and sequencer busy
      OFF_STAT: read_mux = {rd_count_reg, rd_byte_reg, 2'h0,
                            rd_byte_reg[ST_D0_B] | rd_byte_reg[ST_D1_B],
                            ~rd_byte_reg[ST_PROT_B], rd_byte_reg[ST_FAIL_B],
                            err_reg, READY_BUSY_N_IN, state_reg != ST_IDLE};
      default: read_mux = 32'h0;
    endcase
  endfunction

  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      dp_valid_reg <= 1'b0;
      dp_write_reg <= 1'b0;
      dp_addr_reg <= 8'h00;
      hrdata_reg <= 32'h0;
    end else if (CLK_EN_IN) begin
      if (HREADY_IN) begin
        dp_valid_reg <= HSEL_IN & HTRANS_IN[1];
        dp_write_reg <= HWRITE_IN;
        dp_addr_reg <= HADDR_IN[7:0];
        if (HSEL_IN & HTRANS_IN[1] & ~HWRITE_IN) begin
          hrdata_reg <= read_mux(HADDR_IN[7:0]);
        end
      end
    end
  end

  // Only one order is queued; a second order stalls the bus instead
  assign is_op = (dp_addr_reg == OFF_CMD) | (dp_addr_reg == OFF_AGO) | (dp_addr_reg == OFF_DATA);
  assign stall = dp_valid_reg & dp_write_reg & is_op & (state_reg != ST_IDLE);
  assign wr_ok = dp_valid_reg & dp_write_reg & ~stall;
  assign HREADYOUT_OUT = ~stall;
  assign HRESP_OUT = 1'b0;
  assign HRDATA_OUT = hrdata_reg;

  // ------------------------------------------------------------
  // Order decode
  // ------------------------------------------------------------
  always_comb begin
    op_next = '{kind: K_CMD, val: HWDATA_IN[7:0], idx: 3'h0, last: 3'h0};
    refuse = 1'b0;
    case (dp_addr_reg)
      OFF_AGO: begin
        op_next.kind = K_ADDR;
        case (HWDATA_IN[1:0])
          AGO_COL: op_next.last = 3'h1; // Column change after 05 or 85
          AGO_ROW: begin
            op_next.idx = 3'h2; // Row only, as erase wants
            op_next.last = 3'h4;
          end
          default: op_next.last = 3'h4;
        endcase
      end
      OFF_DATA: begin
        op_next.kind = HWDATA_IN[DATA_RD_B] ? K_DRD : K_DWR;
        // Data input is only a legal cycle with write-protect high
        refuse = ~HWDATA_IN[DATA_RD_B] & ~ctrl_reg[CTRL_WPN_B];
      end
      default: op_next.kind = K_CMD;
    endcase
  end

  assign start = wr_ok & is_op & ~refuse;

  // Strobes stay high while the device is busy, except what it accepts then
  assign need_ready = ~((op_reg.kind == K_CMD) &
                        ((op_reg.val == OP_STAT) | (op_reg.val == OP_MSTAT) | (op_reg.val == OP_RESET)))
                      & ~((op_reg.kind == K_DRD) & stat_mode_reg);
  assign cur_byte = (op_reg.kind == K_ADDR) ? addr_byte(op_reg.idx, col_reg, row_reg) : op_reg.val;

  // ------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      ctrl_reg <= CTRL_RST;
      col_reg <= '0;
      row_reg <= '0;
      err_reg <= 1'b0;
    end else if (CLK_EN_IN) begin
      if (wr_ok & (dp_addr_reg == OFF_CTRL)) begin
        ctrl_reg <= HWDATA_IN[1:0];
      end
      if (wr_ok & (dp_addr_reg == OFF_COL)) begin
        // Column stays inside the 4224-byte page
        col_reg <= (HWDATA_IN[12:0] > COL_LAST) ? COL_LAST : HWDATA_IN[12:0];
      end
      if (wr_ok & (dp_addr_reg == OFF_ROW)) begin
        row_reg <= {HWDATA_IN[ROW_W-1:WL_W], HWDATA_IN[WL_W-1:0]};
      end
      // A refusal in the clearing cycle still sets the flag
      if (wr_ok & refuse) begin
        err_reg <= 1'b1;
      end else if (wr_ok & (dp_addr_reg == OFF_STAT) & HWDATA_IN[STAT_ERR_B]) begin
        err_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Chip select
  // ------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      ce_n_reg <= 1'b1;
    end else if (CLK_EN_IN) begin
      // Released when idle and not held by software, so the device may sleep
      ce_n_reg <= ~(ctrl_reg[CTRL_CE_B] | start | (state_reg != ST_IDLE));
    end
  end

  // ------------------------------------------------------------
  // Cycle sequencer
  // ------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      state_reg <= ST_IDLE;
      op_reg <= '{kind: K_CMD, val: OP_READ, idx: 3'h0, last: 3'h0};
      cnt_reg <= 4'h0;
      pins_reg <= '{cle: 1'b0, ale: 1'b0, we_n: 1'b1, ostb_n: 1'b1, oe_n: 1'b1, dout: 8'h00};
      stat_mode_reg <= 1'b0;
    end else if (CLK_EN_IN) begin
      case (state_reg)
        ST_IDLE: begin
          if (start) begin
            op_reg <= op_next;
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // Ready pin is pulled up outside, so it reads high when released
          if (~need_ready | READY_BUSY_N_IN) begin
            pins_reg.cle <= op_reg.kind == K_CMD;
            pins_reg.ale <= op_reg.kind == K_ADDR;
            if (op_reg.kind == K_DRD) begin
              // Bus released so the device can drive it while strobed
              pins_reg.oe_n <= 1'b1;
              pins_reg.ostb_n <= 1'b0;
              cnt_reg <= RD_LOW_CYC - 4'h1;
            end else begin
              pins_reg.oe_n <= 1'b0;
              pins_reg.dout <= cur_byte;
              pins_reg.we_n <= 1'b0;
              cnt_reg <= WP_CYC - 4'h1;
            end
            if (op_reg.kind == K_CMD) begin
              stat_mode_reg <= (op_reg.val == OP_STAT) | (op_reg.val == OP_MSTAT);
            end
            state_reg <= ST_LOW;
          end
        end
        ST_LOW: begin
          if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
          end else begin
            pins_reg.we_n <= 1'b1; // Latch edge
            pins_reg.ostb_n <= 1'b1;
            cnt_reg <= WH_CYC - 4'h1;
            state_reg <= ST_HIGH;
          end
        end
        ST_HIGH: begin
          if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
          end else if ((op_reg.kind == K_ADDR) & (op_reg.idx != op_reg.last)) begin
            op_reg.idx <= op_reg.idx + 3'h1; // Consecutive address cycles
            state_reg <= ST_WAIT;
          end else begin
            pins_reg.cle <= 1'b0;
            pins_reg.ale <= 1'b0;
            pins_reg.oe_n <= 1'b1;
            // After a command the busy pin may lag; after address, reads must wait
            case (op_reg.kind)
              K_CMD: cnt_reg <= WB_CYC - 4'h1;
              K_ADDR: cnt_reg <= WHR_CYC - 4'h1;
              default: cnt_reg <= DGAP_CYC - 4'h1;
            endcase
            state_reg <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
          end else begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Read capture
  // ------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      rd_byte_reg <= 8'h00;
      rd_count_reg <= 16'h0;
    end else if (CLK_EN_IN) begin
      // Sampled at the end of the low phase, before the strobe rises
      if ((state_reg == ST_LOW) & (cnt_reg == 4'h0) & (op_reg.kind == K_DRD)) begin
        rd_byte_reg <= SHARED_BUS_IN;
        rd_count_reg <= rd_count_reg + 16'h1;
      end
      if (start & (op_next.kind == K_CMD) & (op_next.val != OP_STAT) & (op_next.val != OP_MSTAT)) begin
        rd_count_reg <= 16'h0;
      end
    end
  end

  // ------------------------------------------------------------
  // Pins
  // ------------------------------------------------------------
  assign CMD_LATCH_OUT = pins_reg.cle;
  assign ADDR_LATCH_OUT = pins_reg.ale;
  assign CHIP_SEL_N_OUT = ce_n_reg;
  assign WRITE_STROBE_N_OUT = pins_reg.we_n;
  assign OUTPUT_STROBE_N_OUT = pins_reg.ostb_n;
  assign WRITE_PROT_N_OUT = ctrl_reg[CTRL_WPN_B];
  assign SHARED_BUS_OUT = pins_reg.dout;
  assign SHARED_BUS_OE_N_OUT = pins_reg.oe_n;
endmodule

// ### bench/ncp_sva.sv
// Checker for the flash port pins of the host controller
`timescale 1ns/1ps
module ncp_sva (
  // Clock and reset
  input wire logic SYS_CLK_IN,
  input wire logic RST_IN,
  // Bus ready and flash port
  input wire logic HREADYOUT_OUT,
  input wire logic CMD_LATCH_OUT,
  input wire logic ADDR_LATCH_OUT,
  input wire logic CHIP_SEL_N_OUT,
  input wire logic WRITE_STROBE_N_OUT,
  input wire logic OUTPUT_STROBE_N_OUT,
  input wire logic WRITE_PROT_N_OUT,
  input wire logic [7:0] SHARED_BUS_OUT,
  input wire logic SHARED_BUS_OE_N_OUT,
  input wire logic READY_BUSY_N_IN
);
  wire cle = CMD_LATCH_OUT;
  wire ale = ADDR_LATCH_OUT;
  wire we_n = WRITE_STROBE_N_OUT;
  wire re_n = OUTPUT_STROBE_N_OUT;
  wire [7:0] d = SHARED_BUS_OUT;
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RST_IN);
  property p_latch_excl; !(cle && ale); endproperty
  a_latch_excl: assert property (p_latch_excl) else $error("both latches high");
  property p_sel; (cle || ale || !we_n || !re_n) |-> !CHIP_SEL_N_OUT; endproperty
  a_sel: assert property (p_sel) else $error("cycle without chip select");
  property p_strobe_excl; we_n || re_n; endproperty
  a_strobe_excl: assert property (p_strobe_excl) else $error("both strobes low");
  property p_drive; !we_n |-> !SHARED_BUS_OE_N_OUT; endproperty
  a_drive: assert property (p_drive) else $error("write strobe with bus released");
  property p_hold; $rose(we_n) |-> $stable(d) && $stable(cle) && $stable(ale); endproperty
  a_hold: assert property (p_hold) else $error("byte or latch moved at strobe rise");
  property p_we_pulse; $fell(we_n) |=> we_n; endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write pulse length");
  property p_re_pulse; $fell(re_n) |=> !re_n ##1 re_n; endproperty
  a_re_pulse: assert property (p_re_pulse) else $error("read pulse length");
  property p_release; !re_n |-> SHARED_BUS_OE_N_OUT; endproperty
  a_release: assert property (p_release) else $error("host drives during read");
  property p_protect; $fell(we_n) && !cle && !ale |-> WRITE_PROT_N_OUT; endproperty
  a_protect: assert property (p_protect) else $error("data input while protected");
  // Status and reset may reach a busy device; everything else waits for ready
  property p_wait; $fell(we_n) && !(cle && d inside {8'h70, 8'h71, 8'hff}) |-> $past(READY_BUSY_N_IN); endproperty
  a_wait: assert property (p_wait) else $error("write cycle while busy");
  c_cmd: cover property ($fell(we_n) && cle);
  c_read: cover property ($fell(re_n));
  c_stall: cover property (!HREADYOUT_OUT);
endmodule
bind ncp_host ncp_sva u_sva (.SYS_CLK_IN(SYS_CLK_IN), .RST_IN(RST_IN), .HREADYOUT_OUT(HREADYOUT_OUT),
  .CMD_LATCH_OUT(CMD_LATCH_OUT), .ADDR_LATCH_OUT(ADDR_LATCH_OUT), .CHIP_SEL_N_OUT(CHIP_SEL_N_OUT),
  .WRITE_STROBE_N_OUT(WRITE_STROBE_N_OUT), .OUTPUT_STROBE_N_OUT(OUTPUT_STROBE_N_OUT),
  .WRITE_PROT_N_OUT(WRITE_PROT_N_OUT), .SHARED_BUS_OUT(SHARED_BUS_OUT),
  .SHARED_BUS_OE_N_OUT(SHARED_BUS_OE_N_OUT), .READY_BUSY_N_IN(READY_BUSY_N_IN));

// ### bench/ncp_flash_model.sv
// Behavioural flash device on the far side of the host controller
`timescale 1ns/1ps
module ncp_flash_model #(
  // Lands on a falling clock edge, so the busy release never races a rising sampling edge
  parameter int BUSY_NS = 2010,
  parameter logic [7:0] ID_BYTE = 8'h3c // Arbitrary value
) (
  // Pins from the host
  input wire logic cle,
  input wire logic ale,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic wp_n,
  input wire logic [7:0] host_d,
  input wire logic host_oe_n,
  // Resolved bus and busy line
  output logic [7:0] bus,
  output logic rb_n
);
  logic [7:0] page [64];
  logic [7:0] adr [5];
  logic [7:0] cmd = 8'h00;
  logic [7:0] q = 8'h00;
  logic [12:0] col = 13'h0;
  logic [2:0] an = 3'h0;
  logic busy = 1'b0;
  logic standby;
  initial for (int i = 0; i < 64; i++) page[i] = 8'(i) ^ 8'h5a;
  assign standby = ce_n && !busy;
  assign rb_n = !busy;
  // Released bus shows the inverse byte so a stale value never passes
  assign bus = !host_oe_n ? host_d : (!ce_n && we_n && !re_n) ? q : ~q;
  always @(posedge busy) begin
    #(BUSY_NS);
    busy = 1'b0;
  end
  always @(posedge we_n) begin
    if (!ce_n && cle && !ale && (!busy || bus inside {8'h70, 8'h71, 8'hff})) begin
      cmd = bus;
      an = 3'h0;
      if (bus == 8'hff) busy = 1'b0;
      if (bus inside {8'h30, 8'h35, 8'h10, 8'h11, 8'hd0} && (wp_n || bus[7:4] == 4'h3)) busy = 1'b1;
    end else if (!ce_n && ale && !cle && !busy && an < 3'h5) begin
      adr[an] = bus;
      if (an == 3'h1) col = {bus[4:0], adr[0]};
      an = an + 3'h1;
    end else if (!ce_n && !cle && !ale && wp_n && !busy) begin
      page[col[5:0]] = bus;
      col = col + 13'h1;
    end
  end
  always @(negedge re_n) begin
    if (!ce_n && we_n && cmd inside {8'h70, 8'h71}) q = {wp_n, !busy, !busy, 5'h0};
    else if (!ce_n && we_n && cmd == 8'h90) q = ID_BYTE;
    else if (!ce_n && we_n) begin
      q = page[col[5:0]];
      col = col + 13'h1;
    end
  end
endmodule

// ### bench/tb_ncp_host.sv
// Self-checking bench of the flash port host controller
`timescale 1ns/1ps
`define CHK(a, e, m) begin cmp_count++; if ((a) !== (e)) begin num_errors++; $display("ERROR %0t %s", $time, m); end end
module tb_ncp_host;
  import ncp_pkg::*;
  localparam logic [12:0] C = 13'h1023;
  localparam logic [17:0] R = 18'h2a5c3;
  localparam logic [39:0] AEXP = {C[7:0], 3'h0, C[12:8], R[7:0], R[15:8], 6'h0, R[17:16]};
  logic clk;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rq;
  int num_errors = 0;
  int cmp_count = 0;
  int nbusy = 0;
  wire [31:0] hrdata;
  wire [7:0] bus, hd;
  wire hready, hresp, cle, ale, ce_n, we_n, re_n, wp_n, oe_n, rb_n;
  ncp_host DUT (.SYS_CLK_IN(clk), .RST_IN(rst), .CLK_EN_IN(clk_en), .HSEL_IN(1'b1), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata), .HREADY_IN(hready),
    .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .CMD_LATCH_OUT(cle), .ADDR_LATCH_OUT(ale),
    .CHIP_SEL_N_OUT(ce_n), .WRITE_STROBE_N_OUT(we_n), .OUTPUT_STROBE_N_OUT(re_n), .WRITE_PROT_N_OUT(wp_n),
    .SHARED_BUS_IN(bus), .SHARED_BUS_OUT(hd), .SHARED_BUS_OE_N_OUT(oe_n), .READY_BUSY_N_IN(rb_n));
  ncp_flash_model M (.cle(cle), .ale(ale), .ce_n(ce_n), .we_n(we_n), .re_n(re_n), .wp_n(wp_n),
    .host_d(hd), .host_oe_n(oe_n), .bus(bus), .rb_n(rb_n));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(negedge rb_n) nbusy++;
  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  // Ready is looked at mid-cycle, so the value seen is the one the next edge samples
  task automatic rdy();
    int i;
    i = 0;
    @(negedge clk);
    while (hready !== 1'b1 && i < 5000) begin
      i++;
      @(negedge clk);
    end
    if (i >= 5000) begin
      num_errors++;
      $display("ERROR %0t bus timeout", $time);
      final_report();
    end
    rq = hrdata;
    @(posedge clk);
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
  endtask
  task automatic cmd(input logic [7:0] op);
    xfer(1'b1, OFF_CMD, {24'h0, op});
  endtask
  task automatic dw(input logic [7:0] b);
    xfer(1'b1, OFF_DATA, {24'h0, b});
  endtask
  task automatic idle();
    rq = 32'h1;
    for (int i = 0; i < 300 && rq[0] !== 1'b0; i++) xfer(1'b0, OFF_STAT, 32'h0);
    if (rq[0] !== 1'b0) begin
      num_errors++;
      $display("ERROR %0t sequencer timeout", $time);
      final_report();
    end
  endtask
  task automatic rdb();
    xfer(1'b1, OFF_DATA, 32'h100);
    idle();
    xfer(1'b0, OFF_DATA, 32'h0);
  endtask
  task automatic addr(input logic [12:0] c, input logic [1:0] m);
    xfer(1'b1, OFF_COL, {19'h0, c});
    xfer(1'b1, OFF_ROW, {14'h0, R});
    xfer(1'b1, OFF_AGO, {30'h0, m});
    idle();
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    `CHK({ce_n, cle, ale, we_n, re_n, oe_n, wp_n, hresp, hready}, 9'b100111001, "pins after reset")
    xfer(1'b0, 8'h1c, 32'h0);
    `CHK(rq, 32'h0, "unmapped read")
    xfer(1'b1, OFF_CTRL, 32'h3);
    addr(13'h0005, 2'h0);
    cmd(OP_READ_GO);
    rdb();
    `CHK(rq[7:0], 8'h05 ^ 8'h5a, "first read")
    rdb();
    `CHK(rq[7:0], 8'h06 ^ 8'h5a, "next column")
    `CHK(nbusy, 1, "read busy")
    $display("test reset done");
  endtask
  task automatic t_prog();
    cmd(OP_PROG);
    addr(C, 2'h0);
    `CHK({M.adr[0], M.adr[1], M.adr[2], M.adr[3], M.adr[4]}, AEXP, "address bytes")
    dw(8'ha5);
    dw(8'h5a);
    cmd(OP_COLWR);
    addr(13'h1030, 2'h1);
    dw(8'h77);
    cmd(OP_PROG_GO);
    cmd(OP_STAT);
    rdb();
    `CHK(rq[7:0], 8'h80, "status while busy")
    cmd(OP_READ);
    addr(C, 2'h0);
    cmd(OP_READ_GO);
    rdb();
    `CHK(rq[7:0], 8'ha5, "programmed byte")
    rdb();
    `CHK(rq[7:0], 8'h5a, "second byte")
    cmd(OP_COLRD);
    addr(13'h1030, 2'h1);
    cmd(OP_COLRD_GO);
    rdb();
    `CHK(rq[7:0], 8'h77, "redirected byte")
    $display("test program done");
  endtask
  task automatic t_prot();
    xfer(1'b1, OFF_CTRL, 32'h1);
    cmd(OP_PROG);
    addr(C, 2'h0);
    dw(8'h11);
    xfer(1'b0, OFF_STAT, 32'h0);
    `CHK({wp_n, rq[STAT_ERR_B]}, 2'b01, "protected write")
    `CHK(M.page[6'h23], 8'ha5, "page untouched")
    xfer(1'b1, OFF_STAT, 32'h4);
    xfer(1'b0, OFF_STAT, 32'h0);
    `CHK(rq[STAT_ERR_B], 1'b0, "flag cleared")
    $display("test protect done");
  endtask
  task automatic t_ops();
    logic [7:0] ops [5];
    int n0;
    ops = '{OP_CPBK, OP_MPROG_1, OP_MPROG_2, OP_PROG_GO, OP_ECC};
    n0 = nbusy;
    xfer(1'b1, OFF_CTRL, 32'h3);
    cmd(OP_ERASE);
    addr(C, 2'h2);
    cmd(OP_ERASE_GO);
    cmd(OP_MSTAT);
    rdb();
    `CHK(rq[7:0], 8'h80, "multi status busy")
    cmd(OP_ID);
    rdb();
    `CHK(rq[7:0], M.ID_BYTE, "id after ready")
    foreach (ops[i]) cmd(ops[i]);
    `CHK(nbusy - n0, 4, "busy operations")
    cmd(OP_STAT);
    rdb();
    `CHK(rq[7:0], 8'he0, "status ready")
    xfer(1'b0, OFF_STAT, 32'h0);
    `CHK(rq, 32'h0001e002, "decoded status")
    $display("test opcodes done");
  endtask
  task automatic t_standby();
    xfer(1'b1, OFF_CTRL, 32'h0);
    // Enable low must freeze the chip select that the cleared hold bit would release
    clk_en <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK(ce_n, 1'b0, "frozen by clock enable")
    clk_en <= 1'b1;
    idle();
    `CHK({ce_n, wp_n, M.standby}, 3'b101, "deselected idle")
    $display("test standby done");
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_prog();
    t_prot();
    t_ops();
    t_standby();
    final_report();
  end
endmodule
